// [design/owcd_decode.sv]
// Combinational decoder from the raw option word to the individual modes.
// Assumes the word is stable while its outputs are sampled.
`timescale 1ns/1ps
module owcd_decode
    import owcd_pkg::*;
(
    input  wire logic [5:0] raw_word,   // Option word as stored
    output owcd_mode_t      mode,       // Decoded mode signals
    output logic [5:0]      clean_word  // Word with reserved bit forced
);

    wire logic osc_type  = raw_word[OWCD_BIT_TYPE];
    wire logic freq_bit  = raw_word[OWCD_BIT_FREQ];

    assign clean_word = raw_word | OWCD_RSV_MASK;

    assign mode.rc_osc_mode       = ~osc_type;
    assign mode.high_crystal_mode = osc_type & freq_bit;
    assign mode.low_crystal_mode  = osc_type & ~freq_bit;
    assign mode.cycle_four_period = raw_word[OWCD_BIT_CYCLE];
    assign mode.watchdog_enable   = ~raw_word[OWCD_BIT_WDT_N];
    assign mode.power_save_level  = raw_word[OWCD_BIT_VOLT];
    // The frequency bit is ignored in RC mode; a set bit there is only reported.
    assign mode.freq_conflict     = ~osc_type & freq_bit;

endmodule

// [design/owcd_pkg.sv]
// Package for the option word configuration decoder: register map, option bit
// positions, reset values, divider counts and the carrier types.
// Assumes one clock domain (pclk) and an APB slave with 32-bit data.
package owcd_pkg;

    // Option word layout.
    localparam int OWCD_WORD_W    = 6;
    localparam int OWCD_BIT_VOLT  = 0;
    localparam int OWCD_BIT_CYCLE = 1;
    localparam int OWCD_BIT_WDT_N = 2;
    localparam int OWCD_BIT_FREQ  = 3;
    localparam int OWCD_BIT_TYPE  = 4;
    localparam int OWCD_BIT_RSV   = 5;

    localparam logic [5:0] OWCD_RSV_MASK = 6'h20;
    // Safe word shown until the stored word is captured: RC, two periods,
    // watchdog on, wide voltage range.
    localparam logic [5:0] OWCD_WORD_RST = 6'h20;

    // APB map, byte addresses.
    localparam int         OWCD_ADDR_W        = 8;
    localparam logic [7:0] OWCD_OFS_CFG_WORD  = 8'h00;
    localparam logic [7:0] OWCD_OFS_CFG_MODE  = 8'h04;
    localparam logic [7:0] OWCD_OFS_TICK_CTRL = 8'h08;
    localparam logic [7:0] OWCD_OFS_TICK_CNT  = 8'h0C;

    // Field positions.
    localparam int OWCD_FLD_VALID = 8;
    localparam int OWCD_FLD_RUN   = 0;
    localparam int OWCD_FLD_CLR   = 1;

    // Reset values.
    localparam logic [31:0] OWCD_RDATA_RST = 32'h0000_0000;
    localparam logic        OWCD_RUN_RST   = 1'b0;
    localparam int          OWCD_CNT_W     = 16;
    localparam logic [15:0] OWCD_CNT_RST   = 16'h0000;

    // Timer/counter clock divider: last count of a two or four period cycle.
    localparam int         OWCD_DIV_W         = 2;
    localparam logic [1:0] OWCD_DIV_TWO_LAST  = 2'h1;
    localparam logic [1:0] OWCD_DIV_FOUR_LAST = 2'h3;

    typedef struct packed {
        logic freq_conflict;
        logic power_save_level;
        logic watchdog_enable;
        logic cycle_four_period;
        logic low_crystal_mode;
        logic high_crystal_mode;
        logic rc_osc_mode;
    } owcd_mode_t;

    localparam owcd_mode_t OWCD_MODE_RST = 7'h11;

    typedef enum logic {
        OWCD_LOAD,
        OWCD_HOLD
    } owcd_state_t;

endpackage

// [design/owcd_tick_div.sv]
// Divider that turns the oscillator clock into the timer/counter tick.
// Assumes pclk stands for the oscillator clock.
`timescale 1ns/1ps
module owcd_tick_div
    import owcd_pkg::*;
#(
    parameter int CNT_W = OWCD_DIV_W
)
(
    input  wire logic pclk,        // Oscillator clock
    input  wire logic presetn,     // Asynchronous reset, active low
    input  wire logic run,         // Divider enable
    input  wire logic four_period, // Divide by four instead of two
    output logic      tick         // One-cycle tick pulse
);

    logic [CNT_W-1:0] cnt;
    wire  logic [CNT_W-1:0] last_cnt = four_period ? CNT_W'(OWCD_DIV_FOUR_LAST)
                                                   : CNT_W'(OWCD_DIV_TWO_LAST);
    wire  logic             wrap     = (cnt == last_cnt);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else if (!run) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else begin
            cnt  <= wrap ? '0 : cnt + CNT_W'(1);
            tick <= wrap;
        end
    end

endmodule

// [design/owcd_top.sv]
// Option word configuration decoder: captures the stored option word after
// reset, decodes it into static mode outputs and derives the timer/counter tick.
// Assumes the option word storage drives nv_word steadily and that the APB
// master follows the usual setup/access protocol on pclk.
//
// Summary of operation
// - Option word lives in its own storage, never on the program fetch path.
// - Running code can read option bits over APB but cannot write them; they stay fixed.
// - Bit 0 selects voltage level: 0 wide range, 1 high range power saving.
// - Bit 1 selects instruction cycle: 0 two periods, 1 four periods.
// - Bit 2 is watchdog enable, active low.
// - Bit 3 selects crystal class: 0 low frequency, 1 high frequency.
// - Frequency bit matters only with crystal type; programmer keeps it 0 for RC.
// - Bit 4 selects oscillator type: 0 external RC, 1 crystal or resonator.
// - Bit 5 is reserved and always reads as one.
// - Type 0 gives RC; type 1 with frequency 1 high, else low crystal.
// - With four periods the timer/counter clock is oscillator divided by four.
`timescale 1ns/1ps
module owcd_top
    import owcd_pkg::*;
(
    input  wire logic        pclk,              // System clock, 50 MHz
    input  wire logic        presetn,           // Asynchronous reset, active low
    input  wire logic [5:0]  nv_word,           // Option word from its own storage
    input  wire logic        psel,              // APB select
    input  wire logic        penable,           // APB enable
    input  wire logic        pwrite,            // APB direction, high for write
    input  wire logic [7:0]  paddr,             // APB byte address
    input  wire logic [31:0] pwdata,            // APB write data
    input  wire logic [3:0]  pstrb,             // APB byte lane strobes
    output logic [31:0]      prdata,            // APB read data
    output logic             pready,            // APB ready
    output logic             pslverr,           // APB error
    output logic             cfg_valid,         // Option word captured
    output logic             rc_osc_mode,       // External RC oscillator
    output logic             high_crystal_mode, // High frequency crystal
    output logic             low_crystal_mode,  // Low frequency crystal
    output logic             cycle_four_period, // Four periods per cycle
    output logic             watchdog_enable,   // Watchdog timer on
    output logic             power_save_level,  // High range, power saving
    output logic             timer_counter_tick // Timer/counter clock pulse
);

    owcd_state_t      state;
    owcd_state_t      next_state;
    logic [5:0]       cfg_word;
    owcd_mode_t       cfg_mode;
    owcd_mode_t       dec_mode;
    logic [5:0]       dec_word;
    logic             tick_run;
    logic             tick_clear;
    logic [15:0]      tick_count;
    logic             div_tick;

    // The option word only enters through nv_word; no bus path reaches it.
    owcd_decode u_decode (
        .raw_word   (nv_word),
        .mode       (dec_mode),
        .clean_word (dec_word)
    );

    // Capture happens in the first cycle after reset release, so the outputs
    // show a safe default during reset and never change afterwards.
    wire logic capture = (state == OWCD_LOAD);

    always_comb begin
        case (state)
            OWCD_LOAD: next_state = OWCD_HOLD;
            OWCD_HOLD: next_state = OWCD_HOLD;
            default:   next_state = OWCD_LOAD;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= OWCD_LOAD;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_word  <= OWCD_WORD_RST;
            cfg_mode  <= OWCD_MODE_RST;
            cfg_valid <= 1'b0;
        end else if (capture) begin
            cfg_word  <= dec_word;
            cfg_mode  <= dec_mode;
            cfg_valid <= 1'b1;
        end
    end

    assign rc_osc_mode       = cfg_mode.rc_osc_mode;
    assign high_crystal_mode = cfg_mode.high_crystal_mode;
    assign low_crystal_mode  = cfg_mode.low_crystal_mode;
    assign cycle_four_period = cfg_mode.cycle_four_period;
    assign watchdog_enable   = cfg_mode.watchdog_enable;
    assign power_save_level  = cfg_mode.power_save_level;

    // Timer/counter clock: divide by two or four from the latched cycle length.
    owcd_tick_div #(
        .CNT_W (OWCD_DIV_W)
    ) u_tick_div (
        .pclk        (pclk),
        .presetn     (presetn),
        .run         (tick_run & cfg_valid),
        .four_period (cfg_mode.cycle_four_period),
        .tick        (div_tick)
    );

    assign timer_counter_tick = div_tick;

    // APB decode. One wait state: pready rises in the second access cycle.
    wire logic hit_word  = (paddr == OWCD_OFS_CFG_WORD);
    wire logic hit_mode  = (paddr == OWCD_OFS_CFG_MODE);
    wire logic hit_ctrl  = (paddr == OWCD_OFS_TICK_CTRL);
    wire logic hit_cnt   = (paddr == OWCD_OFS_TICK_CNT);
    wire logic hit_any   = hit_word | hit_mode | hit_ctrl | hit_cnt;
    // Option bits are read-only status; a write to them is refused.
    wire logic ro_write  = pwrite & (hit_word | hit_mode | hit_cnt);
    wire logic bad_acc   = ~hit_any | ro_write;
    wire logic next_pready = psel & penable & ~pready;
    wire logic acc_done  = psel & penable & pready;
    wire logic ctrl_wr   = acc_done & pwrite & hit_ctrl & ~pslverr & pstrb[0];

    wire logic [31:0] rd_word = {23'h00_0000, cfg_valid, 2'h0, cfg_word};
    wire logic [31:0] rd_mode = {25'h000_0000, cfg_mode};
    wire logic [31:0] rd_ctrl = {31'h0000_0000, tick_run};
    wire logic [31:0] rd_cnt  = {16'h0000, tick_count};
    wire logic [31:0] rd_data = hit_word ? rd_word :
                                hit_mode ? rd_mode :
                                hit_ctrl ? rd_ctrl :
                                hit_cnt  ? rd_cnt  : OWCD_RDATA_RST;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= OWCD_RDATA_RST;
            pslverr <= 1'b0;
        end else begin
            pready <= next_pready;
            if (next_pready) begin
                prdata  <= pwrite ? OWCD_RDATA_RST : rd_data;
                pslverr <= bad_acc;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_run   <= OWCD_RUN_RST;
            tick_clear <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                tick_run <= pwdata[OWCD_FLD_RUN];
            end
            tick_clear <= ctrl_wr & pwdata[OWCD_FLD_CLR];
        end
    end

    // A tick arriving with the clear is kept, so no timer pulse is lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_count <= OWCD_CNT_RST;
        end else if (tick_clear) begin
            tick_count <= {15'h0000, div_tick};
        end else begin
            tick_count <= tick_count + {15'h0000, div_tick};
        end
    end

    // Assertions.
    AST_RSV_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_valid |-> cfg_word[OWCD_BIT_RSV] == 1'b1)
        else $error("Reserved option bit not one");

    AST_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(cfg_valid) |-> cfg_word == ($past(nv_word) | OWCD_RSV_MASK))
        else $error("Captured word differs from stored word");

    AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_valid ##1 cfg_valid |-> $stable(cfg_word) && $stable(cfg_mode))
        else $error("Configuration changed after capture");

    AST_VALID_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg_valid |=> cfg_valid)
        else $error("Word not captured one cycle after reset");

    AST_OSC_MODE: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_valid |-> rc_osc_mode == !cfg_word[OWCD_BIT_TYPE]
            && (rc_osc_mode + high_crystal_mode + low_crystal_mode) == 2'd1)
        else $error("Oscillator mode decode wrong");

    AST_XTAL_CLASS: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_valid && cfg_word[OWCD_BIT_TYPE] |->
            high_crystal_mode == cfg_word[OWCD_BIT_FREQ]
            && low_crystal_mode == !cfg_word[OWCD_BIT_FREQ])
        else $error("Crystal class decode wrong");

    AST_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_valid |-> watchdog_enable == !cfg_word[OWCD_BIT_WDT_N]
            && power_save_level == cfg_word[OWCD_BIT_VOLT]
            && cycle_four_period == cfg_word[OWCD_BIT_CYCLE])
        else $error("Mode flag decode wrong");

    AST_TICK_FOUR: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_counter_tick && cycle_four_period && tick_run) ##1 tick_run[*3]
            |-> !timer_counter_tick ##1 timer_counter_tick)
        else $error("Timer tick period not four");

    AST_TICK_TWO: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_counter_tick && !cycle_four_period && tick_run) ##1 tick_run
            |-> !timer_counter_tick ##1 timer_counter_tick)
        else $error("Timer tick period not two");

    AST_NO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && pwrite && hit_word |=> pslverr && pready)
        else $error("Write to option word not refused");

    AST_READY_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable ##1 psel && penable |=> pready)
        else $error("Slave answer not one wait state");

    AST_RESET_SAFE: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg_valid |-> rc_osc_mode && watchdog_enable && !high_crystal_mode
            && !low_crystal_mode && !cycle_four_period && !power_save_level)
        else $error("Mode outputs not at safe default before capture");

    AST_STATE_VALID: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_valid == (state == OWCD_HOLD))
        else $error("Capture flag and state disagree");

    AST_RD_RSV: assert property (@(posedge pclk) disable iff (!presetn)
        acc_done && !pwrite && hit_word |-> prdata[OWCD_BIT_RSV] == 1'b1)
        else $error("Reserved option bit read as zero");

    AST_NO_WRITE_MODE: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && pwrite && hit_mode |=> pslverr && pready)
        else $error("Write to mode register not refused");

    AST_NO_WRITE_CNT: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && pwrite && hit_cnt |=> pslverr && pready)
        else $error("Write to tick count not refused");

    AST_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && !hit_any |=> pslverr && pready)
        else $error("Unmapped access not refused");

    AST_WR_ZERO_DATA: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && pwrite |=> prdata == OWCD_RDATA_RST)
        else $error("Read data not zero after a write");

    AST_READY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("Ready held longer than one cycle");

    AST_READY_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        !psel |=> !pready)
        else $error("Ready raised without a selected access");

    AST_RUN_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_wr |=> tick_run == $past(pwdata[OWCD_FLD_RUN]))
        else $error("Run bit did not take the written value");

    AST_CTRL_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_wr |=> $stable(tick_run))
        else $error("Run bit changed without a write");

    AST_TICK_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        !tick_run |=> !timer_counter_tick)
        else $error("Timer tick while stopped");

    AST_TICK_NO_CFG: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg_valid |=> !timer_counter_tick)
        else $error("Timer tick before the word was captured");

    AST_TICK_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
        timer_counter_tick |=> !timer_counter_tick)
        else $error("Timer tick longer than one cycle");

    AST_CLR_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        tick_clear |=> !tick_clear)
        else $error("Counter clear not self clearing");

    AST_CNT_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        tick_clear |=> tick_count == {15'h0000, $past(div_tick)})
        else $error("Tick count wrong after clear");

    AST_CNT_STEP: assert property (@(posedge pclk) disable iff (!presetn)
        !tick_clear |=> tick_count == $past(tick_count) + {15'h0000, $past(div_tick)})
        else $error("Tick count did not follow the ticks");

    COV_LOAD: cover property (@(posedge pclk) disable iff (!presetn) $rose(cfg_valid));
    COV_LXT:  cover property (@(posedge pclk) disable iff (!presetn)
        cfg_valid && low_crystal_mode);
    COV_TICK4: cover property (@(posedge pclk) disable iff (!presetn)
        timer_counter_tick && cycle_four_period);
    COV_ERR:  cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
    COV_HXT:  cover property (@(posedge pclk) disable iff (!presetn)
        cfg_valid && high_crystal_mode);

endmodule

// [dv/owcd_tb_top.sv]
// Self-checking bench for the option word configuration decoder.
// Assumes owcd_top from design/ and its package; the bench is the only APB master.
`timescale 1ns/1ps
module owcd_tb_top;
    import owcd_pkg::*;

    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic [5:0]  nv_word = 6'h00;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [3:0]  pstrb   = 4'hf;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cfg_valid;
    logic        rc_osc_mode;
    logic        high_crystal_mode;
    logic        low_crystal_mode;
    logic        cycle_four_period;
    logic        watchdog_enable;
    logic        power_save_level;
    logic        timer_counter_tick;
    int          n_mismatch = 0;
    int          checks     = 0;
    int          cyc        = 0;
    int          tick_seen  = 0;
    wire  [5:0]  mode_pins  = {power_save_level, watchdog_enable, cycle_four_period,
                               low_crystal_mode, high_crystal_mode, rc_osc_mode};

    owcd_top uut (
        .pclk               (pclk),
        .presetn            (presetn),
        .nv_word            (nv_word),
        .psel               (psel),
        .penable            (penable),
        .pwrite             (pwrite),
        .paddr              (paddr),
        .pwdata             (pwdata),
        .pstrb              (pstrb),
        .prdata             (prdata),
        .pready             (pready),
        .pslverr            (pslverr),
        .cfg_valid          (cfg_valid),
        .rc_osc_mode        (rc_osc_mode),
        .high_crystal_mode  (high_crystal_mode),
        .low_crystal_mode   (low_crystal_mode),
        .cycle_four_period  (cycle_four_period),
        .watchdog_enable    (watchdog_enable),
        .power_save_level   (power_save_level),
        .timer_counter_tick (timer_counter_tick)
    );

    always #10 pclk = ~pclk;

    // The ceiling allows about four times the expected run length.
    always @(posedge pclk) begin
        cyc++;
        if (presetn && timer_counter_tick === 1'b1) begin
            tick_seen++;
        end
        if (cyc == 3000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic results();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is seen at an edge.
    task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= wr;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic        er;
        apb(a, 1'b0, 32'h0000_0000, rd, er);
        cmp({31'h0, er}, {31'h0, exp_err});
        if (!exp_err) begin
            cmp(rd, exp);
        end
    endtask

    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic exp_err);
        logic [31:0] rd;
        logic        er;
        apb(a, 1'b1, d, rd, er);
        cmp({31'h0, er}, {31'h0, exp_err});
    endtask

    function automatic logic [6:0] exp_mode(input logic [5:0] w);
        exp_mode = {~w[4] & w[3], w[0], ~w[2], w[1], w[4] & ~w[3], w[4] & w[3], ~w[4]};
    endfunction

    logic [5:0] words [6] = '{6'h00, 6'h1f, 6'h10, 6'h18, 6'h08, 6'h27};

    initial begin
        int t0;
        int div;
        foreach (words[i]) begin
            presetn <= 1'b0;
            nv_word <= words[i];
            repeat (5) @(posedge pclk);
            cmp({24'h00_0000, cfg_valid, pready, mode_pins}, {24'h00_0000, 2'b00, 6'h11});
            presetn <= 1'b1;
            repeat (2) @(posedge pclk);
            cmp({31'h0, cfg_valid}, 32'h0000_0001);
            cmp({25'h0, 1'b0, mode_pins}, {25'h0, exp_mode(words[i]) & 7'h3f});
            rd_chk(OWCD_OFS_CFG_WORD, {23'h0, 1'b1, 2'b00, words[i] | 6'h20}, 1'b0);
            rd_chk(OWCD_OFS_CFG_MODE, {25'h0, exp_mode(words[i])}, 1'b0);
            // A changed strap must not reach the outputs until the next reset.
            nv_word <= ~words[i];
            repeat (3) @(posedge pclk);
            cmp({25'h0, 1'b0, mode_pins}, {25'h0, exp_mode(words[i]) & 7'h3f});
            wr_chk(OWCD_OFS_CFG_WORD, 32'h0000_003f, 1'b1);
            wr_chk(OWCD_OFS_CFG_MODE, 32'h0000_0000, 1'b1);
            rd_chk(OWCD_OFS_CFG_WORD, {23'h0, 1'b1, 2'b00, words[i] | 6'h20}, 1'b0);
            rd_chk(8'h10, 32'h0000_0000, 1'b1);
            // Tick rate: a 40-cycle window holds a whole number of periods.
            div = words[i][1] ? 4 : 2;
            wr_chk(OWCD_OFS_TICK_CTRL, 32'h0000_0003, 1'b0);
            t0 = tick_seen;
            repeat (8) @(posedge pclk);
            t0 = tick_seen;
            repeat (40) @(posedge pclk);
            cmp(32'(tick_seen - t0), 32'(40 / div));
            wr_chk(OWCD_OFS_TICK_CTRL, 32'h0000_0000, 1'b0);
            repeat (6) @(posedge pclk);
            t0 = tick_seen;
            repeat (8) @(posedge pclk);
            cmp(32'(tick_seen - t0), 32'h0000_0000);
            // Run lasts 52 cycles between the two one-wait-state writes.
            rd_chk(OWCD_OFS_TICK_CNT, 32'(52 / div), 1'b0);
            // A write with byte lane 0 off must leave the run bit clear.
            pstrb <= 4'h0;
            wr_chk(OWCD_OFS_TICK_CTRL, 32'h0000_0001, 1'b0);
            pstrb <= 4'hf;
            rd_chk(OWCD_OFS_TICK_CTRL, 32'h0000_0000, 1'b0);
            $display("test word %h done", words[i]);
        end
        results();
    end
endmodule
